/* src/flash_spi_pkg.sv */
package flash_spi_pkg;

  // Sizes
  localparam int ADDR_W     = 19;
  localparam int CNT_W      = 12;
  localparam int PAGE_BYTES = 256;

  // One-byte command codes
  localparam logic [7:0] CMD_WEN    = 8'h06;
  localparam logic [7:0] CMD_WDIS   = 8'h04;
  localparam logic [7:0] CMD_SREAD  = 8'h05;
  localparam logic [7:0] CMD_SWRITE = 8'h01;
  localparam logic [7:0] CMD_PROG   = 8'h02;
  localparam logic [7:0] CMD_SERASE = 8'hD8;
  localparam logic [7:0] CMD_BERASE = 8'hC7;

  // Frame lengths in bytes
  localparam logic [8:0] SWR_MIN_BYTES  = 9'h002;
  localparam logic [8:0] SER_BYTES      = 9'h004;
  localparam logic [8:0] BER_BYTES      = 9'h001;
  localparam logic [8:0] PRG_HDR_BYTES  = 9'h004;
  localparam logic [8:0] PRG_MIN_BYTES  = 9'h005;
  localparam logic [8:0] PAGE_CNT       = 9'h100;

  // Status byte layout
  localparam int BIT_BUSY  = 0;
  localparam int BIT_LATCH = 1;
  localparam int BIT_BP_LO = 2;
  localparam int BIT_BP_HI = 4;
  localparam int BIT_LOCK  = 7;

  // Reset values of the latch and, until the strap load, of block protect
  localparam logic       LATCH_RST = 1'b0;
  localparam logic [2:0] BP_RST    = 3'h0;

  // Lower bounds of the protected top region
  localparam logic [ADDR_W-1:0] PROT_EIGHTH  = 19'h70000;
  localparam logic [ADDR_W-1:0] PROT_QUARTER = 19'h60000;
  localparam logic [ADDR_W-1:0] PROT_HALF    = 19'h40000;

  // Internal cycle sequencer
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PROG = 3'b010,
    ST_WAIT = 3'b100
  } seq_e;

endpackage

/* src/sync2.sv */
module sync2
  import flash_spi_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and reset of the receiving side
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Async level in, synced level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q_ff
);

  logic [W-1:0] meta_ff;

  // Two flops; only the second is read outside
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= '0;
      q_ff    <= '0;
    end
    else
    begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

endmodule

/* src/spi_link.sv */
module spi_link
  import flash_spi_pkg::*;
(
  // Serial pins
  input  wire logic             sck,
  input  wire logic             cs_n,
  input  wire logic             si,
  input  wire logic             hold_n,
  input  wire logic             rst_n,
  // Status already synced to sck
  input  wire logic [7:0]       status_s,
  // Frame results, quiet once deselected
  output logic      [7:0]       opcode_ff,
  output logic      [23:0]      addr_ff,
  output logic      [CNT_W-1:0] bits_ff,
  // Page buffer read port
  input  wire logic [7:0]       buf_raddr,
  output logic      [7:0]       buf_rdata,
  // Serial output
  output logic                  so_ff,
  output logic                  so_oe_ff
);

  logic [7:0]       page_mem [PAGE_BYTES];
  logic [6:0]       sh_ff;
  logic             first_ff;
  wire              frame_rst_n = rst_n & ~cs_n;
  wire  [CNT_W-1:0] cur_cnt     = first_ff ? '0 : bits_ff;
  wire  [CNT_W-1:0] nxt_bits    = (&cur_cnt) ? cur_cnt : cur_cnt + 1'b1;
  wire  [7:0]       byte_w      = {sh_ff, si};
  wire              byte_end    = nxt_bits[2:0] == 3'h0;
  wire  [7:0]       widx        = addr_ff[7:0] + nxt_bits[10:3] - 8'h05;
  wire              sread_w     = !first_ff && opcode_ff == CMD_SREAD && bits_ff >= 12'h008;
  wire  [2:0]       out_idx     = 3'h7 - bits_ff[2:0];

  // Shifter restarts whenever chip select rises, paused or not
  always_ff @(posedge sck or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      sh_ff    <= '0;
      first_ff <= 1'b1;
    end
    else if (hold_n)
    begin
      sh_ff    <= byte_w[6:0];
      first_ff <= 1'b0;
    end
  end

  // Frame record survives deselect so the system side can read it
  always_ff @(posedge sck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bits_ff   <= '0;
      opcode_ff <= '0;
      addr_ff   <= '0;
    end
    else if (hold_n && !cs_n)
    begin
      bits_ff <= nxt_bits;
      if (byte_end && nxt_bits == 12'h008)
        opcode_ff <= byte_w;
      else if (byte_end && nxt_bits <= 12'h020)
        addr_ff <= {addr_ff[15:0], byte_w};
    end
  end

  // Data bytes wrap inside the page
  always_ff @(posedge sck)
  begin
    if (hold_n && !cs_n && byte_end && nxt_bits > 12'h020 && opcode_ff == CMD_PROG)
      page_mem[widx] <= byte_w;
  end

  assign buf_rdata = page_mem[buf_raddr];

  // Output moves on falling edges; cleared while deselected
  always_ff @(negedge sck or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      so_ff    <= 1'b0;
      so_oe_ff <= 1'b0;
    end
    else
    begin
      so_oe_ff <= hold_n && sread_w;
      so_ff    <= status_s[out_idx];
    end
  end

endmodule

/* src/flash_spi_front.sv */
// How it works
// - Serial output changes on falling clock edges, ready for the next rise.
// - Command, address and data bits are captured on rising clock edges.
// - Deselected: output floats; standby unless an internal cycle runs.
// - Clock may idle low or high; sample on rise, drive on fall.
// - Everything moves in whole bytes.
// - One page program takes up to 256 bytes wrapping within one page.
// - Sector erase or bulk erase sets the region to all ones.
// - Busy bit stays set for the whole internal cycle, then clears.
// - Chip select rising mid-cycle keeps the part active until done.
// - Modifying commands need the latch; completion and disable clear it.
// - Block-protect field selects a protected top region; writes there refused.
// - Hardware protection makes lock and block-protect bits read-only.
// - Program, erase, status write run only on whole-byte frames.
// - Pause gates the clock, keeps bit position, spares internal cycles.
// - Pause starts only while selected, aligned to clock low.
// - Pause ends on pause release aligned to clock low.
// - Paused: output floats from the next falling clock edge, data and clock ignored, state kept.
// - Deselect during pause resets the link; master releases pause first.
// - Hardware protection is lock bit set with protect pin low.
// - All bytes travel most significant bit first.
module flash_spi_front
  import flash_spi_pkg::*;
(
  // System clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // Serial link, clocked by the master
  input  wire logic              sck,
  input  wire logic              cs_n,
  input  wire logic              si,
  input  wire logic              hold_n,
  input  wire logic              wp_n,
  output logic                   so,
  output logic                   so_oe,
  // Nonvolatile status loaded after reset: lock, protect[2:0]
  input  wire logic [3:0]        nv_init,
  // Array engine side
  input  wire logic              op_done,
  output logic                   mem_wr_en_ff,
  output logic                   mem_wr_last_ff,
  output logic      [ADDR_W-1:0] mem_addr_ff,
  output logic      [7:0]        mem_wdata_ff,
  output logic                   erase_req_ff,
  output logic                   erase_all_ff,
  output logic                   nv_wr_req_ff,
  output logic      [3:0]        nv_data_ff,
  // Status and power
  output logic      [7:0]        status_byte_ff,
  output logic                   standby_ff
);

  // Protected-region lookup, used by decode and checks
  function automatic logic prot_hit(input logic [2:0] lvl, input logic [ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    unique case (lvl)
      3'h0: hit = 1'b0;
      3'h1: hit = a >= PROT_EIGHTH;
      3'h2: hit = a >= PROT_QUARTER;
      3'h3: hit = a >= PROT_HALF;
      default: hit = 1'b1;
    endcase
    return hit;
  endfunction

  seq_e              state_ff;
  seq_e              nxt_state;
  logic              cs_s;
  logic              hold_s;
  logic              wp_s;
  logic              cs_q_ff;
  logic              seen_hi_ff;
  logic              armed_ff;
  logic              load_ff;
  logic              write_enable_latch_ff;
  logic              status_lock_ff;
  logic [2:0]        protect_level_ff;
  logic [3:0]        nv_new_ff;
  logic [ADDR_W-9:0] pg_ff;
  logic [7:0]        off_ff;
  logic [8:0]        left_ff;
  logic [7:0]        status_s;
  logic [7:0]        opcode;
  logic [23:0]       addr;
  logic [CNT_W-1:0]  bits;
  logic [7:0]        buf_rdata;
  logic              nv_wr_pend_ff;

  // Pin levels into the system clock
  sync2 #(.W(3)) u_pin_sync (
    .clk   (clk_sys),
    .rst_n (rst_n),
    .d     ({cs_n, hold_n, wp_n}),
    .q_ff  ({cs_s, hold_s, wp_s})
  );

  // Status into the link clock; only read after the opcode byte
  sync2 #(.W(8)) u_stat_sync (
    .clk   (sck),
    .rst_n (rst_n),
    .d     (status_byte_ff),
    .q_ff  (status_s)
  );

  // Link-side shifter and page buffer
  spi_link u_link (
    .sck       (sck),
    .cs_n      (cs_n),
    .si        (si),
    .hold_n    (hold_n),
    .rst_n     (rst_n),
    .status_s  (status_s),
    .opcode_ff (opcode),
    .addr_ff   (addr),
    .bits_ff   (bits),
    .buf_raddr (off_ff),
    .buf_rdata (buf_rdata),
    .so_ff     (so),
    .so_oe_ff  (so_oe)
  );

  // Frame decode; link record is stable two edges after deselect
  wire              busy_w   = state_ff != ST_IDLE;
  wire              end_w    = cs_s & ~cs_q_ff;
  wire              fall_w   = cs_q_ff & ~cs_s;
  wire              len_ok   = bits[2:0] == 3'h0;
  wire [8:0]        nbytes   = bits[CNT_W-1:3];
  wire [ADDR_W-1:0] faddr    = addr[ADDR_W-1:0];
  wire              hwprot_w = status_lock_ff & ~wp_s;
  wire              go       = end_w & armed_ff & hold_s & len_ok & ~busy_w & ~load_ff;
  wire              latch_w  = write_enable_latch_ff;
  wire              go_wen   = go & (opcode == CMD_WEN);
  wire              go_wdis  = go & (opcode == CMD_WDIS);
  wire              go_swr   = go & (opcode == CMD_SWRITE) & latch_w & ~hwprot_w & (nbytes >= SWR_MIN_BYTES);
  wire              go_prog  = go & (opcode == CMD_PROG) & latch_w & (nbytes >= PRG_MIN_BYTES)
                               & ~prot_hit(protect_level_ff, faddr);
  wire              go_ser   = go & (opcode == CMD_SERASE) & latch_w & (nbytes == SER_BYTES)
                               & ~prot_hit(protect_level_ff, faddr);
  wire              go_ber   = go & (opcode == CMD_BERASE) & latch_w & (nbytes == BER_BYTES)
                               & (protect_level_ff == BP_RST);
  wire              done_w   = (state_ff == ST_WAIT) & op_done;
  wire [8:0]        ndata    = nbytes - PRG_HDR_BYTES;
  wire [8:0]        nprog    = (ndata > PAGE_CNT) ? PAGE_CNT : ndata;
  wire [8:0]        skip     = ndata - nprog;
  wire [7:0]        start    = addr[7:0] + skip[7:0];
  wire              last_w   = left_ff == 9'h001;
  wire [7:0]        status_w = {status_lock_ff, 2'b00, protect_level_ff, latch_w, busy_w};

  // Sequencer for program, erase and status store
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE:
      begin
        if (go_prog)
          nxt_state = ST_PROG;
        else if (go_swr || go_ser || go_ber)
          nxt_state = ST_WAIT;
      end
      ST_PROG:
      begin
        if (last_w)
          nxt_state = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (op_done)
          nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Chip select history; a frame counts only after a seen deselect
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_q_ff    <= 1'b0;
      seen_hi_ff <= 1'b0;
      armed_ff   <= 1'b0;
    end
    else
    begin
      cs_q_ff    <= cs_s;
      seen_hi_ff <= seen_hi_ff | cs_s;
      if (fall_w)
        armed_ff <= seen_hi_ff;
    end
  end

  // Write-enable latch; disable and completion both clear it
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      write_enable_latch_ff <= LATCH_RST;
    else if (go_wen)
      write_enable_latch_ff <= 1'b1;
    else if (go_wdis || done_w)
      write_enable_latch_ff <= 1'b0;
  end

  // Nonvolatile bits: strap after reset, new value at store completion
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      load_ff          <= 1'b1;
      status_lock_ff   <= 1'b0;
      protect_level_ff <= BP_RST;
      nv_new_ff        <= '0;
    end
    else
    begin
      load_ff <= 1'b0;
      if (load_ff)
        {status_lock_ff, protect_level_ff} <= nv_init;
      else if (done_w && nv_new_ff != {status_lock_ff, protect_level_ff} && nv_wr_pend_ff)
        {status_lock_ff, protect_level_ff} <= nv_new_ff;
      if (go_swr)
        nv_new_ff <= {addr[BIT_LOCK], addr[BIT_BP_HI:BIT_BP_LO]};
    end
  end

  // Remembers that the running cycle is a status store
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      nv_wr_pend_ff <= 1'b0;
    else if (go_swr)
      nv_wr_pend_ff <= 1'b1;
    else if (done_w)
      nv_wr_pend_ff <= 1'b0;
  end

  // Page stream pointer; a long burst keeps only the last page's worth
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pg_ff   <= '0;
      off_ff  <= '0;
      left_ff <= '0;
    end
    else if (go_prog)
    begin
      pg_ff   <= faddr[ADDR_W-1:8];
      off_ff  <= start;
      left_ff <= nprog;
    end
    else if (state_ff == ST_PROG)
    begin
      off_ff  <= off_ff + 8'h01;
      left_ff <= left_ff - 9'h001;
    end
  end

  // Array requests; the engine ANDs program data so bits only clear
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_wr_en_ff   <= 1'b0;
      mem_wr_last_ff <= 1'b0;
      mem_addr_ff    <= '0;
      mem_wdata_ff   <= '0;
      erase_req_ff   <= 1'b0;
      erase_all_ff   <= 1'b0;
      nv_wr_req_ff   <= 1'b0;
      nv_data_ff     <= '0;
    end
    else
    begin
      mem_wr_en_ff   <= state_ff == ST_PROG;
      mem_wr_last_ff <= (state_ff == ST_PROG) && last_w;
      erase_req_ff   <= go_ser | go_ber;
      nv_wr_req_ff   <= go_swr;
      if (state_ff == ST_PROG)
      begin
        mem_addr_ff  <= {pg_ff, off_ff};
        mem_wdata_ff <= buf_rdata;
      end
      else if (go_ser || go_ber)
      begin
        mem_addr_ff  <= go_ber ? '0 : {faddr[ADDR_W-1:16], 16'h0000};
        erase_all_ff <= go_ber;
      end
      if (go_swr)
        nv_data_ff <= {addr[BIT_LOCK], addr[BIT_BP_HI:BIT_BP_LO]};
    end
  end

  // Visible status and power mode; pause spares a running cycle, but a frame ended while paused starts none
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_byte_ff <= '0;
      standby_ff     <= 1'b0;
    end
    else
    begin
      status_byte_ff <= status_w;
      standby_ff     <= cs_s & ~busy_w;
    end
  end

  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_prog_start;
    (state_ff == ST_IDLE) ##1 (state_ff == ST_PROG);
  endsequence

  sequence s_cycle_start;
    (state_ff == ST_IDLE) ##1 (state_ff != ST_IDLE);
  endsequence

  a_busy_flag: assert property (busy_w |=> status_byte_ff[BIT_BUSY])
    else $error("busy bit not shown during internal cycle");

  a_done_clears_latch: assert property (done_w |=> !write_enable_latch_ff)
    else $error("latch not cleared at cycle completion");

  a_no_latch_refused: assert property ((end_w && !latch_w && !busy_w) |=> state_ff == ST_IDLE)
    else $error("modifying command started without latch");

  a_whole_bytes: assert property (s_cycle_start |-> $past(len_ok))
    else $error("internal cycle started from a partial byte frame");

  a_prog_unprot: assert property (mem_wr_en_ff |-> !prot_hit(protect_level_ff, mem_addr_ff))
    else $error("program write into protected region");

  a_prog_bounded: assert property (s_prog_start |-> ##[0:256] (state_ff == ST_WAIT))
    else $error("page stream longer than one page");

  a_standby_wait: assert property ((cs_s && busy_w) |=> !standby_ff)
    else $error("standby entered during internal cycle");

  a_standby_entry: assert property ((cs_s && !busy_w) |=> standby_ff)
    else $error("standby not entered when idle and deselected");

  a_hwprot_frozen: assert property ((hwprot_w && !busy_w && !load_ff) |=> $stable(protect_level_ff) && $stable(status_lock_ff))
    else $error("protected status bits changed in hardware protection");

  a_hwprot_refuse: assert property ((go && hwprot_w && opcode == CMD_SWRITE) |=> !nv_wr_req_ff)
    else $error("status write accepted in hardware protection");

  a_erase_sector: assert property (go_ser |=> erase_req_ff && !erase_all_ff && mem_addr_ff[15:0] == 16'h0000)
    else $error("sector erase request malformed");

endmodule

/* test/spi_master_model.sv */
module spi_master_model
  import flash_spi_pkg::*;
(
  // Link pins driven toward the device
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  output logic      hold_n,
  // Device serial output
  input  wire logic so,
  input  wire logic so_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  logic cpol;

  // Idle levels; the clock stands still between frames
  initial
  begin
    cpol = 1'b0;
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b1;
    hold_n = 1'b1;
  end

  // Change clock polarity only while deselected
  task automatic set_mode(input logic c);
    cpol = c;
    sck <= c;
    #6;
  endtask

  // One frame, MSB first; optional pause before bit hold_at
  task automatic xfer(input logic [7:0] b[$], input int extra, input int hold_at,
                      output logic [7:0] rd, output logic oe_hold);
    int n;
    n = b.size() * 8 + extra;
    rd = 8'h00;
    oe_hold = 1'b1;
    #3.7;
    cs_n <= 1'b0;
    #6;
    for (int i = 0; i < n; i++)
    begin
      sck <= 1'b0;
      if (i == hold_at)
      begin
        #3;
        hold_n <= 1'b0;
        #3;
        // Clock and data toggle while paused; both must be ignored
        repeat (3)
        begin
          sck <= 1'b1;
          si <= ~si;
          #6;
          sck <= 1'b0;
          #6;
        end
        oe_hold = so_oe;
        hold_n <= 1'b1;
        #3;
      end
      si <= (i < b.size() * 8) ? b[i / 8][7 - i % 8] : 1'b0;
      #6;
      sck <= 1'b1;
      rd = {rd[6:0], so};
      #6;
    end
    sck <= cpol;
    #6;
    cs_n <= 1'b1;
    si <= ~si;  // Released line shows no stale value
  endtask
endmodule

/* test/serial_flash_spi_front_end_tb_top.sv */
module serial_flash_spi_front_end_tb_top
  import flash_spi_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int DONE_DLY = 40;  // Engine busy span, short to keep the run brief

  logic              clk_sys, rst_n, wp_n, op_done, sck, cs_n, si, hold_n, so, so_oe;
  logic              mem_wr_en_ff, mem_wr_last_ff, erase_req_ff, erase_all_ff, nv_wr_req_ff;
  logic              standby_ff, oe_h, ers_all;
  logic [ADDR_W-1:0] mem_addr_ff, ers_addr;
  logic [7:0]        mem_wdata_ff, status_byte_ff, rd;
  logic [3:0]        nv_init, nv_data_ff, nv_seen;
  logic [ADDR_W-1:0] wr_addr[$];
  logic [7:0]        wr_data[$];
  int                failures = 0, comparisons = 0, ers_cnt = 0, nv_cnt = 0, stby_bad = 0, dly = 0, n;
  logic [2:0]        bp_tab[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  logic [23:0]       lo_tab[4] = '{24'h000000, 24'h070000, 24'h060000, 24'h040000};

  // System clock
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  flash_spi_front DUT (
    .clk_sys, .rst_n, .sck, .cs_n, .si, .hold_n, .wp_n, .so, .so_oe, .nv_init, .op_done,
    .mem_wr_en_ff, .mem_wr_last_ff, .mem_addr_ff, .mem_wdata_ff, .erase_req_ff, .erase_all_ff,
    .nv_wr_req_ff, .nv_data_ff, .status_byte_ff, .standby_ff
  );

  spi_master_model M (.sck, .cs_n, .si, .hold_n, .so, .so_oe);

  // Array engine stand-in and traffic log
  always @(posedge clk_sys)
  begin
    op_done <= 1'b0;
    if (mem_wr_last_ff || erase_req_ff || nv_wr_req_ff)
      dly <= DONE_DLY;
    else if (dly != 0)
    begin
      dly <= dly - 1;
      op_done <= (dly == 1);
    end
    if (mem_wr_en_ff)
    begin
      wr_addr.push_back(mem_addr_ff);
      wr_data.push_back(mem_wdata_ff);
    end
    if (erase_req_ff)
    begin
      ers_cnt++;
      ers_addr = mem_addr_ff;
      ers_all = erase_all_ff;
    end
    if (nv_wr_req_ff)
    begin
      nv_cnt++;
      nv_seen = nv_data_ff;
    end
    if (standby_ff && status_byte_ff[BIT_BUSY])
      stby_bad++;
  end

  function automatic logic [7:0] sb(input logic lock, input logic [2:0] bp, input logic latch, input logic busy);
    return {lock, 2'b00, bp, latch, busy};
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Frame plus the idle gap that the sync chain needs
  task automatic frame(input logic [7:0] b[$], input int extra = 0, input int hold_at = -1);
    M.xfer(b, extra, hold_at, rd, oe_h);
    repeat (8) @(posedge clk_sys);
  endtask

  // Bounded poll; a stuck busy shows in the next status compare
  task automatic wait_idle();
    repeat (DONE_DLY + 300)
    begin
      @(posedge clk_sys);
      if (status_byte_ff[BIT_BUSY] === 1'b0)
        break;
    end
    @(posedge clk_sys);
  endtask

  task automatic st_chk(input string nm, input logic [7:0] exp);
    frame({CMD_SREAD, 8'h00, 8'h00});
    chk(nm, exp, rd);
    chk("so_oe_deselected", 0, so_oe);
  endtask

  task automatic swrite(input logic [7:0] v);
    frame({CMD_WEN});
    frame({CMD_SWRITE, v});
    wait_idle();
  endtask

  task automatic prog(input logic [23:0] a);
    frame({CMD_WEN});
    frame({CMD_PROG, a[23:16], a[15:8], a[7:0], 8'h3C});
    wait_idle();
  endtask

  task automatic end_sim();
    if (failures == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    nv_init = 4'h2;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk("standby_idle", 1, standby_ff);
    st_chk("st_reset", sb(1'b0, 3'h2, 1'b0, 1'b0));
    // Pause in mid-opcode and in mid-readout
    frame({CMD_WEN}, 0, 4);
    st_chk("st_latch", sb(1'b0, 3'h2, 1'b1, 1'b0));
    frame({CMD_SREAD, 8'h00, 8'h00}, 0, 12);
    chk("so_oe_pause", 0, oe_h);
    chk("st_after_pause", sb(1'b0, 3'h2, 1'b1, 1'b0), rd);
    frame({CMD_WDIS});
    st_chk("st_disable", sb(1'b0, 3'h2, 1'b0, 1'b0));
    // Program without latch, then a ragged frame: both dropped
    frame({CMD_PROG, 8'h00, 8'h01, 8'hFE, 8'h5A});
    chk("prog_no_latch", 0, wr_addr.size());
    frame({CMD_WEN});
    frame({CMD_PROG, 8'h00, 8'h01, 8'hFE, 8'h5A}, 7);
    chk("prog_ragged", 0, wr_addr.size());
    // Latch survives the refusal; the burst wraps inside its page
    frame({CMD_PROG, 8'h00, 8'h01, 8'hFE, 8'h5A, 8'hC3, 8'h81});
    st_chk("st_busy", sb(1'b0, 3'h2, 1'b1, 1'b1));
    wait_idle();
    chk("prog_cnt", 3, wr_addr.size());
    chk("prog_a0", 19'h001FE, wr_addr[0]);
    chk("prog_a2", 19'h00100, wr_addr[2]);
    chk("prog_d2", 8'h81, wr_data[2]);
    st_chk("st_done", sb(1'b0, 3'h2, 1'b0, 1'b0));
    // Clock idling high
    M.set_mode(1'b1);
    frame({CMD_WEN});
    st_chk("st_mode3", sb(1'b0, 3'h2, 1'b1, 1'b0));
    M.set_mode(1'b0);
    // Protect codes 0-4 and 7: top byte, and the byte just under the region
    for (int p = 0; p < 6; p++)
    begin
      swrite(sb(1'b0, bp_tab[p], 1'b0, 1'b0));
      st_chk("st_bp", sb(1'b0, bp_tab[p], 1'b0, 1'b0));
      n = wr_addr.size();
      prog(24'h07FFFF);
      chk("prot_top", p == 0, wr_addr.size() - n);
      if (p > 0 && p < 4)
      begin
        prog(lo_tab[p] - 24'h000001);
        chk("prot_below", n + 1, wr_addr.size());
      end
    end
    // Whole array protected: both erases refused
    frame({CMD_WEN});
    frame({CMD_BERASE});
    frame({CMD_SERASE, 8'h00, 8'h10, 8'h00});
    chk("erase_prot", 0, ers_cnt);
    swrite(8'h00);
    frame({CMD_WEN});
    frame({CMD_SERASE, 8'h03, 8'hAB, 8'hCD});
    wait_idle();
    chk("sector_base", 19'h30000, ers_addr);
    chk("sector_kind", 0, ers_all);
    frame({CMD_WEN});
    frame({CMD_BERASE});
    wait_idle();
    chk("bulk_kind", 1, ers_all);
    chk("bulk_base", 0, ers_addr);
    chk("erase_cnt", 2, ers_cnt);
    // Lock bit with the protect pin low freezes the status bits
    swrite(8'h8C);
    chk("nv_data", 4'hB, nv_seen);
    wp_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    n = nv_cnt;
    swrite(8'h00);
    chk("hwprot_block", n, nv_cnt);
    st_chk("st_hwprot", sb(1'b1, 3'h3, 1'b1, 1'b0));
    wp_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    swrite(8'h00);
    st_chk("st_unlock", 8'h00);
    chk("stby_busy", 0, stby_bad);
    chk("standby_end", 1, standby_ff);
    end_sim();
  end

  // Hang guard; the sequence needs well under a quarter of this
  initial
  begin
    #2_000_000;
    failures++;
    end_sim();
  end
endmodule
